// ---- test_timer_gate_toggle.sv ----
// testbench of the gated counter with gate toggle conditioning
// assumes tgt_pkg, tgt_top and the gate source model
`timescale 1ns/100ps
module test_timer_gate_toggle;
   import tgt_pkg::*;
   localparam int HALF = 5;
   localparam int OVF_P = 7;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   tgt_wb_req_s req = '0;
   logic [TGT_DW-1:0] dat;
   logic ack;
   logic pin;
   logic alt;
   logic ovf;
   logic [15:0] cnt;
   logic gate;
   logic ovf_out;
   int err_count = 0;
   int checked = 0;
   logic [31:0] rd;
   logic [31:0] snap;

   always #2 clk_i = ~clk_i;

   tgt_gate_src #(.HALF(HALF), .OVF_P(OVF_P)) i_tgt_gate_src (
      .clk_i(clk_i), .rst_i(rst_i), .pin_o(pin), .alt_o(alt), .ovf_o(ovf));
   tgt_top #(.CNT_W(16)) i_tgt_top (
      .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(dat),
      .wb_ack_o(ack), .gate_pin_i(pin), .gate_alt_i(alt),
      .ovf_src_i(ovf), .count_o(cnt), .gate_o(gate), .ovf_o(ovf_out));

   // ====
   // common tasks
   task wrap_up;
      if (err_count == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : wrap_up

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task xfer(input logic we, input logic [3:0] a, input logic [31:0] d);
      int n;
      logic ok;
      n = 0;
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 16);
      ok = (ack === 1'b1);
      rd = dat;
      req <= '0;
      @(posedge clk_i);
      if (!ok) begin
         chk(32'h0, 32'h1);
         wrap_up;
      end
   endtask : xfer

   task wait_gate(input logic v);
      int n;
      n = 0;
      while (gate !== v && n < 64) begin
         @(posedge clk_i);
         n++;
      end
      if (gate !== v) begin
         chk({31'h0, gate}, {31'h0, v});
         wrap_up;
      end
   endtask : wait_gate

   task hold_low;
      // the clear lands one edge after the write, gate lags one more
      @(posedge clk_i);
      snap = {16'h0, cnt};
      repeat (4 * HALF) begin
         @(posedge clk_i);
         chk({31'h0, gate}, 32'h0);
      end
      chk({16'h0, cnt}, snap);
   endtask : hold_low

   function automatic logic [31:0] gcr(input logic tm, input logic sp,
      input tgt_gsel_e s);
      return {24'h0, s, 1'b0, sp, sp, tm, 2'b11};
   endfunction : gcr

   // ====
   // scenarios
   task t_reset;
      xfer(1'b1, 4'h1, 32'hffff_ffff);
      xfer(1'b0, 4'h1, 32'h0);
      chk(rd, 32'h0);
      // gate enable is off after reset, so the gate flag reads high
      for (int i = 0; i < 16; i += 4) begin
         xfer(1'b0, 4'(i), 32'h0);
         chk(rd, (i == 0) ? 32'h20 : 32'h0);
      end
   endtask : t_reset

   task t_pulse(input logic tm, input tgt_gsel_e s, input int exp);
      xfer(1'b1, TGT_CTL_ADR, 32'h0);
      xfer(1'b1, TGT_CNT_ADR, 32'h0);
      // arm only once running, so no pulse is lost while stopped
      xfer(1'b1, TGT_GCR_ADR, gcr(tm, 1'b1, s) & ~32'h10);
      xfer(1'b1, TGT_CTL_ADR, 32'h1);
      xfer(1'b1, TGT_GCR_ADR, gcr(tm, 1'b1, s));
      repeat (40) @(posedge clk_i);
      xfer(1'b0, TGT_CNT_ADR, 32'h0);
      chk(rd, 32'(exp));
      xfer(1'b0, TGT_GCR_ADR, 32'h0);
      chk(rd & 32'h10, (exp == 0) ? 32'h10 : 32'h0);
   endtask : t_pulse

   task t_free_run;
      int n;
      xfer(1'b1, TGT_CNT_ADR, 32'h0);
      xfer(1'b1, TGT_GCR_ADR, gcr(1'b1, 1'b0, TGT_SEL_PIN));
      xfer(1'b1, TGT_CTL_ADR, 32'h1);
      wait_gate(1'b0);
      wait_gate(1'b1);
      n = 0;
      while (gate === 1'b1 && n < 50) begin
         @(posedge clk_i);
         n++;
      end
      chk(32'(n), 32'(2 * HALF));
      wait_gate(1'b1);
      xfer(1'b1, TGT_CTL_ADR, 32'h0);
      hold_low;
      xfer(1'b1, TGT_CTL_ADR, 32'h1);
      wait_gate(1'b1);
      xfer(1'b1, TGT_GCR_ADR, gcr(1'b0, 1'b0, TGT_SEL_OFF));
      xfer(1'b1, TGT_GCR_ADR, gcr(1'b1, 1'b0, TGT_SEL_OFF));
      hold_low;
   endtask : t_free_run

   task t_wrap;
      int n;
      xfer(1'b1, TGT_CTL_ADR, 32'h0);
      xfer(1'b1, TGT_GCR_ADR, 32'h0);
      xfer(1'b1, TGT_CNT_ADR, 32'h0000_fff0);
      xfer(1'b1, TGT_CTL_ADR, 32'h1);
      n = 0;
      while (ovf_out !== 1'b1 && n < 64) begin
         @(posedge clk_i);
         n++;
      end
      chk({31'h0, ovf_out}, 32'h1);
      chk(32'(n), 32'h10);
      chk({16'h0, cnt}, 32'h0);
      xfer(1'b1, TGT_CTL_ADR, 32'h0);
      xfer(1'b0, TGT_STS_ADR, 32'h0);
      chk(rd, 32'h1);
      xfer(1'b1, TGT_STS_ADR, 32'h1);
      xfer(1'b0, TGT_STS_ADR, 32'h0);
      chk(rd, 32'h0);
   endtask : t_wrap

   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_pulse(1'b0, TGT_SEL_PIN, HALF);
      t_pulse(1'b0, TGT_SEL_ALT, HALF);
      t_pulse(1'b1, TGT_SEL_PIN, 2 * HALF);
      t_pulse(1'b0, TGT_SEL_OVF, 1);
      t_pulse(1'b1, TGT_SEL_OVF, OVF_P);
      t_pulse(1'b1, TGT_SEL_OFF, 0);
      t_free_run;
      t_wrap;
      wrap_up;
   end
endmodule : test_timer_gate_toggle

// ---- tgt_gate_src.sv ----
// gate source model: square wave pin, its inverse, overflow pulse
// assumes the bench's clock and synchronous reset
`timescale 1ns/100ps
module tgt_gate_src #(
   parameter int HALF = 5,
   parameter int OVF_P = 7
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // gate sources
   output logic pin_o,
   output logic alt_o,
   output logic ovf_o
);
   int ph_ff;
   int ov_ff;
   assign alt_o = ~pin_o;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ph_ff <= 0;
         ov_ff <= 0;
         pin_o <= 1'b0;
         ovf_o <= 1'b0;
      end else begin
         ph_ff <= (ph_ff == HALF - 1) ? 0 : ph_ff + 1;
         ov_ff <= (ov_ff == OVF_P - 1) ? 0 : ov_ff + 1;
         pin_o <= (ph_ff == HALF - 1) ? ~pin_o : pin_o;
         ovf_o <= (ov_ff == OVF_P - 1);
      end
   end
endmodule : tgt_gate_src

// ---- tgt_pkg.sv ----
// package of the gated counter with gate toggle conditioning
// assumes one 250 MHz clock and a classic Wishbone slave port
package tgt_pkg;

   // ==========================================================
   // bus shape and register offsets (byte addresses)
   localparam int TGT_DW = 32;
   localparam int TGT_AW = 4;
   localparam logic [TGT_AW-1:0] TGT_GCR_ADR = 4'h0;
   localparam logic [TGT_AW-1:0] TGT_CTL_ADR = 4'h4;
   localparam logic [TGT_AW-1:0] TGT_CNT_ADR = 4'h8;
   localparam logic [TGT_AW-1:0] TGT_STS_ADR = 4'hc;

   // ==========================================================
   // field positions
   localparam int GCR_GE_BIT = 0;
   localparam int GCR_POL_BIT = 1;
   localparam int GCR_TM_BIT = 2;
   localparam int GCR_SP_BIT = 3;
   localparam int GCR_GO_BIT = 4;
   localparam int GCR_VAL_BIT = 5;
   localparam int GCR_SEL_LSB = 6;
   localparam int CTL_RUN_BIT = 0;
   localparam int STS_OVF_BIT = 0;

   // ==========================================================
   // values after reset
   localparam logic [6:0] GCR_RST = 7'h00;
   localparam logic CTL_RUN_RST = 1'b0;
   localparam logic [TGT_DW-1:0] CNT_RST = 32'h0000_0000;

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      TGT_SEL_PIN = 2'h0,
      TGT_SEL_OVF = 2'h1,
      TGT_SEL_ALT = 2'h2,
      TGT_SEL_OFF = 2'h3
   } tgt_gsel_e;

   typedef struct packed {
      tgt_gsel_e sel;
      logic go;
      logic sp;
      logic tm;
      logic pol;
      logic ge;
   } tgt_gctl_s;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [TGT_AW-1:0] adr;
      logic [3:0] sel;
      logic [TGT_DW-1:0] dat;
   } tgt_wb_req_s;

   // byte-lane merge of a write into a register word
   function automatic logic [TGT_DW-1:0] tgt_merge(
      input logic [TGT_DW-1:0] old_w,
      input logic [TGT_DW-1:0] new_w,
      input logic [3:0] sel);
      logic [TGT_DW-1:0] res;
      res = old_w;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return res;
   endfunction : tgt_merge

endpackage : tgt_pkg

// ---- tgt_toggle.sv ----
// gate toggle flip-flop: flips on each incrementing gate edge
// assumes edge_i is a one-cycle pulse in the clk_i domain
`timescale 1ns/100ps
module tgt_toggle (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control
   input wire logic enable_i,
   input wire logic edge_i,
   // result
   output logic q_o
);

   // ==========================================================
   // flip-flop, forced and held clear while disabled
   logic nxt_q;

   assign nxt_q = enable_i ? (q_o ^ edge_i) : 1'b0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_o <= 1'b0;
      end else begin
         q_o <= nxt_q;
      end
   end

endmodule : tgt_toggle

// ---- tgt_top.sv ----
// gated counter with gate toggle and single-pulse conditioning
// assumes gate pins and the overflow pulse are synchronous to clk_i
//
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
module tgt_top
   import tgt_pkg::*;
#(
   parameter int CNT_W = 16
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire tgt_wb_req_s wb_req_i,
   output logic [TGT_DW-1:0] wb_dat_o,
   output logic wb_ack_o,
   // gate sources
   input wire logic gate_pin_i,
   input wire logic gate_alt_i,
   input wire logic ovf_src_i,
   // counter state
   output logic [CNT_W-1:0] count_o,
   output logic gate_o,
   output logic ovf_o
);

   // ==========================================================
   // parameter check
   if (CNT_W < 2 || CNT_W > TGT_DW) begin : g_cnt_w_check
      $error("CNT_W out of range");
   end

   // ==========================================================
   // registers
   typedef enum {SP_IDLE, SP_ARMED, SP_ACTIVE} tgt_sp_e;
   tgt_gctl_s gctl_ff;
   tgt_gctl_s nxt_gctl;
   tgt_sp_e sp_ff;
   tgt_sp_e nxt_sp;
   logic run_ff;
   logic nxt_run;
   logic ovf_flag_ff;
   logic nxt_ovf_flag;
   logic src_prev_ff;
   logic cond_prev_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic [TGT_DW-1:0] nxt_dat;
   logic tog_q;

   // ==========================================================
   // bus decode
   // a request is taken while ack is low; a write lands at the edge
   // where the master samples ack high, with the request still standing
   wire bus_req = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
   wire bus_wr = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & wb_ack_o;
   wire hit_gcr = wb_req_i.adr == TGT_GCR_ADR;
   wire hit_ctl = wb_req_i.adr == TGT_CTL_ADR;
   wire hit_cnt = wb_req_i.adr == TGT_CNT_ADR;
   wire hit_sts = wb_req_i.adr == TGT_STS_ADR;
   wire wr_gcr = bus_wr & hit_gcr;
   wire wr_ctl = bus_wr & hit_ctl;
   wire wr_cnt = bus_wr & hit_cnt;
   wire wr_sts = bus_wr & hit_sts;

   wire [TGT_DW-1:0] gcr_word = {24'h000000, gctl_ff.sel, gate_o,
      gctl_ff.go, gctl_ff.sp, gctl_ff.tm, gctl_ff.pol, gctl_ff.ge};
   wire [TGT_DW-1:0] ctl_word = {31'h00000000, run_ff};
   wire [TGT_DW-1:0] cnt_word = TGT_DW'(count_o);
   wire [TGT_DW-1:0] sts_word = {31'h00000000, ovf_flag_ff};

   wire [TGT_DW-1:0] gcr_new = tgt_merge(gcr_word, wb_req_i.dat,
      wb_req_i.sel);
   wire [TGT_DW-1:0] ctl_new = tgt_merge(ctl_word, wb_req_i.dat,
      wb_req_i.sel);
   wire [TGT_DW-1:0] cnt_new = tgt_merge(cnt_word, wb_req_i.dat,
      wb_req_i.sel);
   wire [TGT_DW-1:0] sts_wmask = tgt_merge(32'h00000000, wb_req_i.dat,
      wb_req_i.sel);

   wire [TGT_DW-1:0] rd_data =
      hit_gcr ? gcr_word :
      hit_ctl ? ctl_word :
      hit_cnt ? cnt_word :
      hit_sts ? sts_word : 32'h00000000;

   // ==========================================================
   // gate source selection and polarity
   wire src_raw =
      (gctl_ff.sel == TGT_SEL_PIN) ? gate_pin_i :
      (gctl_ff.sel == TGT_SEL_OVF) ? ovf_src_i :
      (gctl_ff.sel == TGT_SEL_ALT) ? gate_alt_i : 1'b0;
   wire src_level = src_raw ^ ~gctl_ff.pol;
   // the edge detector runs in every mode, so a source already high
   // when toggle is switched on gives no edge
   wire src_rise = src_level & ~src_prev_ff;

   // ==========================================================
   // toggle conditioning
   // run and toggle both gate the flip-flop enable, so clearing either
   // one zeroes it at the next edge and keeps it zero
   wire tog_en = gctl_ff.tm & run_ff;

   tgt_toggle u_toggle (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .enable_i(tog_en),
      .edge_i(src_rise),
      .q_o(tog_q)
   );

   wire cond = gctl_ff.tm ? tog_q : src_level;
   wire cond_rise = cond & ~cond_prev_ff;
   wire cond_fall = ~cond & cond_prev_ff;

   // ==========================================================
   // single-pulse sequencing
   // with toggle on, one armed pulse spans a full source period
   wire sp_done = (sp_ff == SP_ACTIVE) & cond_fall;
   wire sp_gate = ((sp_ff == SP_ARMED) & cond_rise) |
      ((sp_ff == SP_ACTIVE) & cond);

   always_comb begin
      nxt_sp = sp_ff;
      unique case (sp_ff)
         SP_IDLE: begin
            if (gctl_ff.sp & gctl_ff.go) begin
               nxt_sp = SP_ARMED;
            end
         end
         SP_ARMED: begin
            if (~gctl_ff.sp | ~gctl_ff.go) begin
               nxt_sp = SP_IDLE;
            end else if (cond_rise) begin
               nxt_sp = SP_ACTIVE;
            end
         end
         SP_ACTIVE: begin
            if (~gctl_ff.sp | cond_fall) begin
               nxt_sp = SP_IDLE;
            end
         end
      endcase
   end

   // ==========================================================
   // counting
   wire gate_act = ~gctl_ff.ge | (gctl_ff.sp ? sp_gate : cond);
   wire cnt_inc = run_ff & gate_act;
   wire cnt_wrap = cnt_inc & (&count_o);

   assign nxt_cnt = wr_cnt ? cnt_new[CNT_W-1:0] :
      cnt_inc ? count_o + 1'b1 : count_o;

   // ==========================================================
   // register next values
   always_comb begin
      nxt_gctl = gctl_ff;
      if (wr_gcr) begin
         nxt_gctl.ge = gcr_new[GCR_GE_BIT];
         nxt_gctl.pol = gcr_new[GCR_POL_BIT];
         nxt_gctl.tm = gcr_new[GCR_TM_BIT];
         nxt_gctl.sp = gcr_new[GCR_SP_BIT];
         nxt_gctl.go = gcr_new[GCR_GO_BIT];
         nxt_gctl.sel = tgt_gsel_e'(gcr_new[GCR_SEL_LSB +: 2]);
      end else if (sp_done) begin
         nxt_gctl.go = 1'b0;
      end
   end

   assign nxt_run = wr_ctl ? ctl_new[CTL_RUN_BIT] : run_ff;
   assign nxt_ovf_flag = cnt_wrap |
      (ovf_flag_ff & ~(wr_sts & sts_wmask[STS_OVF_BIT]));
   assign nxt_dat = bus_req ? rd_data : 32'h00000000;

   // ==========================================================
   // flip-flops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gctl_ff <= tgt_gctl_s'(GCR_RST);
         run_ff <= CTL_RUN_RST;
         sp_ff <= SP_IDLE;
         count_o <= CNT_RST[CNT_W-1:0];
         ovf_flag_ff <= 1'b0;
         ovf_o <= 1'b0;
         gate_o <= 1'b0;
         src_prev_ff <= 1'b0;
         cond_prev_ff <= 1'b0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         gctl_ff <= nxt_gctl;
         run_ff <= nxt_run;
         sp_ff <= nxt_sp;
         count_o <= nxt_cnt;
         ovf_flag_ff <= nxt_ovf_flag;
         ovf_o <= cnt_wrap;
         gate_o <= gate_act;
         src_prev_ff <= src_level;
         cond_prev_ff <= cond;
         wb_ack_o <= bus_req;
         wb_dat_o <= nxt_dat;
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_toggle_flips: assert property (
      tog_en && src_rise |=> tog_q != $past(tog_q))
      else $error("toggle did not flip on gate edge");

   a_toggle_holds: assert property (
      tog_en && !src_rise |=> $stable(tog_q))
      else $error("toggle changed without gate edge");

   a_bypass_path: assert property (
      !gctl_ff.tm && gctl_ff.ge && !gctl_ff.sp
         |=> gate_o == $past(src_level))
      else $error("gate not bypassed with toggle off");

   a_tm_clear_hold: assert property (
      !gctl_ff.tm ##1 !gctl_ff.tm |-> !tog_q)
      else $error("toggle output not held clear");

   a_run_clear_hold: assert property (
      !run_ff ##1 !run_ff |-> !tog_q)
      else $error("toggle output not cleared by run");

   a_ovf_source: assert property (
      gctl_ff.sel == TGT_SEL_OVF && tog_en && ovf_src_i == gctl_ff.pol
         && !src_prev_ff |=> tog_q != $past(tog_q))
      else $error("overflow source edge did not flip toggle");

   a_count_step: assert property (
      cnt_inc && !wr_cnt |=> count_o == $past(count_o) + 1'b1)
      else $error("counter did not step while gated on");

   a_count_still: assert property (
      !run_ff && !wr_cnt |=> $stable(count_o))
      else $error("counter moved while stopped");

   a_tm_clear_next: assert property (
      !gctl_ff.tm |=> !tog_q)
      else $error("toggle output not cleared by toggle bit");

   a_run_clear_next: assert property (
      !run_ff |=> !tog_q)
      else $error("toggle output not cleared by run bit");

   // single-pulse sequencing
   a_sp_idle_still: assert property (
      gctl_ff.ge && gctl_ff.sp && sp_ff == SP_IDLE |-> !cnt_inc)
      else $error("counted outside a single pulse");

   a_sp_arming: assert property (
      sp_ff == SP_IDLE && gctl_ff.sp && gctl_ff.go |=> sp_ff == SP_ARMED)
      else $error("single pulse not armed by go");

   a_go_cleared: assert property (
      sp_done && !wr_gcr |=> !gctl_ff.go)
      else $error("go bit not cleared at end of pulse");

   // counter and overflow
   a_count_load: assert property (
      wr_cnt |=> count_o == $past(cnt_new[CNT_W-1:0]))
      else $error("counter write did not land");

   a_ovf_sticky: assert property (
      cnt_wrap |=> ovf_flag_ff && ovf_o)
      else $error("wrap did not set overflow");

   a_ovf_clear: assert property (
      wr_sts && sts_wmask[STS_OVF_BIT] && !cnt_wrap |=> !ovf_flag_ff)
      else $error("overflow flag not cleared by write");

   // bus handshake
   a_ack_answer: assert property (
      wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged next cycle");

   a_ack_single: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");

   a_dat_idle_zero: assert property (
      !wb_ack_o |-> wb_dat_o == 32'h00000000)
      else $error("read data not zero outside ack");

endmodule : tgt_top
